// File: pkg/scs_map.svh
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// channels per device and shift word width
`define SCS_NUM_CH          8
// latch value after reset: all channels off
`define SCS_LATCH_RST       8'h00
// select hi time in ns and its cycle count at 40 MHz
`define SCS_CLK_NS          25
`define SCS_SEL_HI_NS       250
`define SCS_SEL_HI_CYC      ((`SCS_SEL_HI_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
// master shift clock divider: half period in mclk cycles (100 ns period min)
`define SCS_SCLK_MIN_NS     100
`define SCS_SCLK_HALF_CYC   ((`SCS_SCLK_MIN_NS / 2 + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
// most devices in a chain at 10 MHz
`define SCS_MAX_CHAIN       16

`endif

// File: pkg/scs_pkg.sv
package scs_pkg;
    // master sequencer states, gray along idle->setup->low->high->done
    typedef enum logic [2:0] {
        SCS_IDLE  = 3'b000,
        SCS_SETUP = 3'b001,
        SCS_LOW   = 3'b011,
        SCS_HIGH  = 3'b010,
        SCS_DONE  = 3'b110
    } scs_state_t;
endpackage

// File: pkg/scs_link_if.sv
`timescale 1ns/1ps
interface scs_link_if;
    logic serial_in;
    logic shift_clock_in;
    logic select_in;
    modport master (
        output serial_in,
        output shift_clock_in,
        output select_in
    );
    modport dev (
        input serial_in,
        input shift_clock_in,
        input select_in
    );
endinterface

// File: hdl/scs_device.sv
`timescale 1ns/1ps
`include "scs_map.svh"
// Functional notes
// RULE_01 - eight bit shift register plus latch
// RULE_02 - msb first, first bit ends channel 7
// RULE_03 - shift data on rising shift clock
// RULE_04 - select rising copies shift register to latch
// RULE_05 - select falling leaves latch unchanged
// RULE_06 - forward select, clock, and serial out
// RULE_07 - forwarded clock follows both clock edges
// RULE_08 - chain acts as one long shift register
// RULE_09 - master sends farthest channel 7 first
// RULE_10 - master rewrites the whole chain always
// RULE_11 - at most sixteen devices at 10 MHz
// RULE_12 - port disabled ignores clock, data, select
// RULE_13 - disabled: all_off high off, low on
// RULE_14 - latch bit one turns channel on
// RULE_15 - all_off high forces every channel off
module scs_device #(
    parameter int NCH = `SCS_NUM_CH
) (
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    scs_link_if.dev             link,
    input  wire logic           serial_port_enable,
    input  wire logic           all_channels_off,
    output logic                serial_out,
    output logic                shift_clock_out,
    output logic                select_out,
    output logic [NCH-1:0]      channel_bias_enable
);
    // reset image of the shift stages, the holding bits and the drive
    localparam logic [NCH-1:0] RST_WORD = NCH'(`SCS_LATCH_RST);

    logic [2:0]     sclk_sync_q;
    logic [2:0]     sel_sync_q;
    logic [1:0]     sdi_sync_q;
    logic [1:0]     en_sync_q;
    logic [1:0]     off_sync_q;
    logic [NCH-1:0] shreg_q;
    logic [NCH-1:0] latch_q;
    logic           sclk_rise;
    logic           sel_rise;
    logic           port_on;

    // latency budget, counted in mclk edges from a pin change:
    //   2 edges  synchroniser output usable by logic
    //   3 edges  shift stage or holding bit updated
    //   3 edges  forwarded clock and select at the chain outputs
    //   4 edges  channel drive after a select rise
    // the forwarded clock and select keep the spacing that the master gave
    // us, only shifted by three edges, while data out changes one edge after
    // the forwarded clock rise; each chained device adds that three-edge shift
    // once, so a long chain stretches the frame but never skews data
    // against clock.
    // limitation: a shift clock phase shorter than one mclk period can
    // be missed by the synchroniser, so the master must divide its clock
    // down far enough.
    // trade-off: sampling every pin with mclk costs latency, but keeps the
    // whole device in one clock domain with no pin-clocked flops.

    // shift clock synchroniser; third stage only for edge detection.
    // reset at the idle level (low) so release gives no false rising edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_sync_q <= 3'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], link.shift_clock_in};
        end
    end

    // select synchroniser; reset high, the deselected level, so the first
    // edge seen after reset is a genuine fall and never a false rise
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_sync_q <= 3'h7;
        end else begin
            sel_sync_q <= {sel_sync_q[1:0], link.select_in};
        end
    end

    // serial data synchroniser, same depth as the clock path, so the data
    // seen at a detected edge is the data that stood at the pin edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sdi_sync_q <= 2'h0;
        end else begin
            sdi_sync_q <= {sdi_sync_q[0], link.serial_in};
        end
    end

    // port enable synchroniser; disabled until the pin has been seen
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            en_sync_q <= 2'h0;
        end else begin
            en_sync_q <= {en_sync_q[0], serial_port_enable};
        end
    end

    // all-off synchroniser; reset asserted so the channels stay off until
    // the pin has been sampled twice, hiding the disabled preset at release
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            off_sync_q <= 2'h3;
        end else begin
            off_sync_q <= {off_sync_q[0], all_channels_off};
        end
    end

    // edges seen only from synchronised stages, gated by the port enable
    // RULE_12 port enable gate
    assign port_on   = en_sync_q[1];
    assign sclk_rise = port_on & sclk_sync_q[1] & ~sclk_sync_q[2];
    assign sel_rise  = port_on & sel_sync_q[1] & ~sel_sync_q[2];

    // one slice per channel: shift stage, holding bit and channel drive.
    // stage 0 takes the synchronised data pin and stage n its lower
    // neighbour, so the first bit of a word walks up to the top stage
    for (genvar n = 0; n < NCH; n++) begin : g_chan
        logic shift_src;

        // stage 0 sees the data pin, the others their lower neighbour
        if (n == 0) begin : g_first
            assign shift_src = sdi_sync_q[1];
        end else begin : g_next
            assign shift_src = shreg_q[n-1];
        end

        // data sampled with clock edge; both paths share equal sync latency
        // RULE_03 rising edge shift
        // RULE_02 msb first order
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                shreg_q[n] <= RST_WORD[n];
            end else if (sclk_rise) begin
                shreg_q[n] <= shift_src;
            end
        end

        // holding bit loads only on select rise; a fall does nothing
        // RULE_04 latch on rise
        // RULE_05 fall holds latch
        // RULE_01 shift plus latch
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                latch_q[n] <= RST_WORD[n];
            end else if (sel_rise) begin
                latch_q[n] <= shreg_q[n];
            end
        end

        // channel drive: override first, then disabled preset, then latch
        // RULE_15 all off override
        // RULE_13 disabled preset
        // RULE_14 one means on
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                channel_bias_enable[n] <= RST_WORD[n];
            end else if (off_sync_q[1]) begin
                channel_bias_enable[n] <= 1'b0;
            end else if (!port_on) begin
                channel_bias_enable[n] <= 1'b1;
            end else begin
                channel_bias_enable[n] <= latch_q[n];
            end
        end
    end

    // forwarded clock follows the input with fixed sync latency; chain
    // length adds that latency per device, a limitation at fast clocks
    // RULE_06 forward outputs
    // RULE_07 both clock edges
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_clock_out <= 1'b0;
        end else begin
            shift_clock_out <= sclk_sync_q[1];
        end
    end

    // forwarded select, reset deselected so the next device sees idle
    // RULE_06 forward select
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            select_out <= 1'b1;
        end else begin
            select_out <= sel_sync_q[1];
        end
    end

    // chain data out is the top stage, registered once more; it is taken
    // before the stage shifts, so the next device gets the outgoing bit
    // RULE_08 chain shift out
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= shreg_q[NCH-1];
        end
    end
endmodule // scs_device

// File: hdl/scs_master.sv
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_master #(
    parameter int NDEV = 1,
    parameter int NCH  = `SCS_NUM_CH
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    scs_link_if.master               link,
    input  wire logic                start,
    input  wire logic [NDEV*NCH-1:0] word,
    output logic                     busy
);
    localparam int NBITS = NDEV * NCH;
    localparam int HALF  = `SCS_SCLK_HALF_CYC;
    localparam int SELHI = `SCS_SEL_HI_CYC;

    scs_pkg::scs_state_t state_q;
    logic [NBITS-1:0]    data_q;
    logic [15:0]         bit_q;
    logic [15:0]         tmr_q;
    logic                sdo_q;
    logic                sclk_q;
    logic                sel_q;

    assign link.serial_in      = sdo_q;
    assign link.shift_clock_in = sclk_q;
    assign link.select_in      = sel_q;

    // sequencer: whole chain word sent msb first (RULE_09, RULE_10), clock
    // divided down from mclk to at least the minimum period
    // RULE_02 msb first send
    // RULE_10 full rewrite
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= scs_pkg::SCS_IDLE;
            data_q  <= '0;
            bit_q   <= 16'h0;
            tmr_q   <= 16'h0;
            sdo_q   <= 1'b0;
            sclk_q  <= 1'b0;
            sel_q   <= 1'b1;
            busy    <= 1'b0;
        end else begin
            case (state_q)
                scs_pkg::SCS_IDLE: begin
                    sel_q <= 1'b1;
                    if (start) begin
                        data_q  <= word;
                        busy    <= 1'b1;
                        sel_q   <= 1'b0;
                        tmr_q   <= 16'(HALF);
                        bit_q   <= 16'(NBITS);
                        state_q <= scs_pkg::SCS_SETUP;
                    end
                end
                scs_pkg::SCS_SETUP: begin
                    sdo_q   <= data_q[NBITS-1];
                    data_q  <= {data_q[NBITS-2:0], 1'b0};
                    state_q <= scs_pkg::SCS_LOW;
                end
                scs_pkg::SCS_LOW: begin
                    if (tmr_q == 16'h0) begin
                        sclk_q  <= 1'b1;
                        tmr_q   <= 16'(HALF);
                        bit_q   <= bit_q - 16'h1;
                        state_q <= scs_pkg::SCS_HIGH;
                    end else begin
                        tmr_q <= tmr_q - 16'h1;
                    end
                end
                scs_pkg::SCS_HIGH: begin
                    if (tmr_q == 16'h0) begin
                        sclk_q <= 1'b0;
                        tmr_q  <= 16'(HALF);
                        if (bit_q == 16'h0) begin
                            state_q <= scs_pkg::SCS_DONE;
                        end else begin
                            state_q <= scs_pkg::SCS_SETUP;
                        end
                    end else begin
                        tmr_q <= tmr_q - 16'h1;
                    end
                end
                scs_pkg::SCS_DONE: begin
                    // select rise latches, then held high the minimum time
                    sel_q <= 1'b1;
                    if (!sel_q) begin
                        tmr_q <= 16'(SELHI);
                    end else if (tmr_q == 16'h0) begin
                        busy    <= 1'b0;
                        state_q <= scs_pkg::SCS_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 16'h1;
                    end
                end
                default: begin
                    state_q <= scs_pkg::SCS_IDLE;
                end
            endcase
        end
    end
endmodule // scs_master

// File: tb/scs_link_asserts.sv
`timescale 1ns/1ps
module scs_link_asserts #(
    parameter int NBITS = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serial_in,
    input wire logic shift_clock_in,
    input wire logic select_in
);
    logic       ck_q;
    logic [7:0] cnt_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // rising shift clocks in the open frame; cleared while deselected
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ck_q  <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            ck_q <= shift_clock_in;
            if (select_in)
                cnt_q <= 8'h00;
            else if (shift_clock_in && !ck_q)
                cnt_q <= cnt_q + 8'h01;
        end
    end
    chk_whole_chain : assert property ($rose(select_in) |-> cnt_q == 8'(NBITS))
        else $error("frame bit count wrong");
    chk_idle_clk : assert property (select_in |-> !shift_clock_in)
        else $error("shift clock active outside frame");
    chk_clk_high : assert property ($rose(shift_clock_in) |-> shift_clock_in[*3])
        else $error("shift clock high phase short");
    chk_clk_low : assert property ($fell(shift_clock_in) |-> !shift_clock_in[*3])
        else $error("shift clock low phase short");
    chk_data_steady : assert property (shift_clock_in |-> $stable(serial_in))
        else $error("data moved while clock high");
    chk_sel_hi : assert property ($rose(select_in) |-> select_in[*8])
        else $error("select high time short");
    chk_frame_open : assert property ($fell(select_in) |-> !shift_clock_in[*3])
        else $error("clock edge too soon after select");
    chk_frame_len : assert property ($fell(select_in) |-> ##[40:300] $rose(select_in))
        else $error("frame not closed in time");
    // main traffic seen
    cover property ($rose(select_in));
    cover property ($rose(shift_clock_in));
    cover property ($fell(select_in));
endmodule // scs_link_asserts

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start = 1'b0;
    logic [15:0] word = 16'h0000;
    logic        en = 1'b1;
    logic        off = 1'b0;
    logic        busy;
    logic        sdo0, sck0, sel0;
    logic [7:0]  ch0, ch1;
    logic [15:0] last = 16'h0000;
    logic [15:0] pat [4] = '{16'ha53c, 16'h0180, 16'hff00, 16'h0001};
    int          fail_count = 0;
    int          tests_run = 0;
    scs_link_if  l0 ();
    scs_link_if  l1 ();
    // far device is fed only from the near one's forwarded pins
    assign l1.serial_in      = sdo0;
    assign l1.shift_clock_in = sck0;
    assign l1.select_in      = sel0;
    // 40 MHz system clock
    always #12.5 mclk = ~mclk;
    scs_master #(.NDEV(2)) scs_master_inst (.mclk(mclk), .sys_rst(sys_rst), .link(l0),
        .start(start), .word(word), .busy(busy));
    scs_device scs_device_inst (.mclk(mclk), .sys_rst(sys_rst), .link(l0),
        .serial_port_enable(en), .all_channels_off(off), .serial_out(sdo0),
        .shift_clock_out(sck0), .select_out(sel0), .channel_bias_enable(ch0));
    scs_device scs_device_inst_far (.mclk(mclk), .sys_rst(sys_rst), .link(l1),
        .serial_port_enable(en), .all_channels_off(off), .serial_out(),
        .shift_clock_out(), .select_out(), .channel_bias_enable(ch1));
    scs_link_asserts #(.NBITS(16)) scs_link_asserts_inst (.mclk(mclk), .sys_rst(sys_rst),
        .serial_in(l0.serial_in), .shift_clock_in(l0.shift_clock_in),
        .select_in(l0.select_in));
    // prints counts and verdict, then stops
    task automatic final_report();
        $display("checks=%0d fails=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // drive just after the edge so nothing races the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one full chain write; disabled port expects the all-on preset
    task automatic send(input logic [15:0] w);
        int i;
        tick(1);
        word  = w;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(20);
        // select falling mid-frame keeps the old setting
        `CHK({ch1, ch0}, en ? last : 16'hffff)
        `CHK(sel0, 1'b0)
        for (i = 0; i < 2000 && busy !== 1'b0; i++)
            tick(1);
        if (busy !== 1'b0) begin
            fail_count++;
            final_report();
        end
        // each chained device adds a few mclk of select lag
        tick(12);
        if (en)
            last = w;
        `CHK({ch1, ch0}, en ? last : 16'hffff)
    endtask
    // main sequence
    initial begin
        tick(20);
        sys_rst = 1'b0;
        tick(1);
        `CHK({ch1, ch0}, 16'h0000)
        `CHK(sel0, 1'b1)
        // back-to-back words; high byte must land in the far device
        foreach (pat[k])
            send(pat[k]);
        en = 1'b0;
        tick(6);
        `CHK({ch1, ch0}, 16'hffff)
        off = 1'b1;
        tick(6);
        `CHK({ch1, ch0}, 16'h0000)
        off = 1'b0;
        send(16'h1234);
        en  = 1'b1;
        off = 1'b1;
        tick(6);
        `CHK({ch1, ch0}, 16'h0000)
        off = 1'b0;
        tick(6);
        `CHK({ch1, ch0}, last)
        final_report();
    end
endmodule // tb
